//--- onchip_debug_trace_module.sv
// Operation
// - force reset register takes background writes only, user writes ignored, reads zero
// - writing one to its bit 0 resets the whole MCU
// - comparator A value is two bytes, reset zero, always readable
// - comparator B value is two bytes, reset zero, always readable
// - comparator byte writes only take effect while not armed
// - eight bytes of registers in the normal memory map
// - fifo upper byte is read only and reads zero in event-only modes
// - reading fifo upper byte does not advance the fifo
// - each unarmed fifo lower byte read advances the fifo; writes ignored
// - event-only modes store bytes in the low half of each word
// - lower byte reads do not advance the fifo while armed
// - unarmed lower reads store last opcode fetch address at the last location
// - fifo is eight deep; ninth read returns what the first stored
// - control register is readable and writable at any time
// - enable bit 7 cannot become one while the MCU is secure
// - writing arm sets arm and its flag; run end or zero write clears
// - bit 5 picks tag or force break requests, only with break enabled
// - break at trigger for end trace, at fifo full for begin trace
// - bit 2 enables direction for A, bit 3 picks read or write
// - bit 0 enables direction for B, bit 1 picks read or write
// - run ends at fifo full for begin trace, at trigger for end trace
// - modes 0011 and 0100 are event-only, storing bytes on B events
`timescale 1ns/1ps
`default_nettype none
module onchip_debug_trace_module
	import debug_trace_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [3:0] reg_index,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic bdm_access,
	output logic [7:0] reg_rdata,
	input wire logic [15:0] cpu_addr,
	input wire logic [7:0] cpu_data,
	input wire logic cpu_valid,
	input wire logic cpu_read,
	input wire logic cpu_opfetch,
	input wire logic cpu_opexec,
	input wire logic [3:0] trig_mode,
	input wire logic begin_trace,
	input wire logic trigger_qualify_select,
	input wire logic secure,
	output logic break_request,
	output logic break_is_tag,
	output logic system_reset_req,
	output logic capture_active,
	output logic match_a_flag,
	output logic match_b_flag,
	output logic [3:0] fifo_valid_count
);
	logic [7:0] cmp_a_hi_r, cmp_a_lo_r, cmp_b_hi_r, cmp_b_lo_r;
	logic module_enable_bit_r;
	logic [5:0] cfg_r;
	run_state_type state_r, state_nxt;
	logic [3:0] cnt_r;
	logic a_seen_r, af_r, bf_r;
	logic [15:0] last_op_r;
	logic [7:0] rdata_r;
	logic brk_r, brk_tag_r, sys_reset_r, active_r;
	logic armed, qual, ha, hb, above_a, below_a, above_b, below_b;
	logic evmode, data_b, trig_ev, store_ev, capture, full_now, run_end;
	logic wr_ctrl, en_nxt, start_run, rd_lo;
	fifo_link_if #(.WIDTH(16)) link ();

	// access decode
	assign wr_ctrl = reg_wr && (reg_index == IDX_CONTROL);
	assign rd_lo = reg_rd && (reg_index == IDX_FIFO_LO);
	assign en_nxt = reg_wdata[EN_BIT] && (module_enable_bit_r || !secure);
	assign start_run = wr_ctrl && en_nxt && reg_wdata[ARM_BIT] && (state_r == RUN_IDLE);
	assign armed = (state_r != RUN_IDLE);

	// comparator value bytes, frozen while armed
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cmp_a_hi_r <= CMP_RESET;
			cmp_a_lo_r <= CMP_RESET;
			cmp_b_hi_r <= CMP_RESET;
			cmp_b_lo_r <= CMP_RESET;
		end else if (reg_wr && !armed) begin
			if (reg_index == IDX_CMP_A_HI) begin
				cmp_a_hi_r <= reg_wdata;
			end else if (reg_index == IDX_CMP_A_LO) begin
				cmp_a_lo_r <= reg_wdata;
			end else if (reg_index == IDX_CMP_B_HI) begin
				cmp_b_hi_r <= reg_wdata;
			end else if (reg_index == IDX_CMP_B_LO) begin
				cmp_b_lo_r <= reg_wdata;
			end
		end
	end

	// control bits, writable at any time
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			module_enable_bit_r <= 1'b0;
			cfg_r <= CFG_RESET;
		end else if (wr_ctrl) begin
			module_enable_bit_r <= en_nxt;
			cfg_r <= reg_wdata[5:0];
		end
	end

	// comparators see only qualified bus cycles of an armed run
	assign qual = armed && cpu_valid && (!trigger_qualify_select || cpu_opexec);
	addr_comparator cmp_a (
		.value({cmp_a_hi_r, cmp_a_lo_r}),
		.addr(cpu_addr),
		.qualify(qual),
		.cpu_read(cpu_read),
		.dir_en(cfg_r[CMP_A_DIRECTION_ENABLE_BIT]),
		.dir(cfg_r[RWA_BIT]),
		.hit(ha),
		.above(above_a),
		.below(below_a)
	);
	// a hit never lands on the excluded direction
	a_dir_guard_a: assert property (@(posedge core_clk) disable iff (rst)
		cfg_r[CMP_A_DIRECTION_ENABLE_BIT] && (cfg_r[RWA_BIT] != cpu_read) |-> !ha)
		else $error("comparator a hit on excluded direction");
	addr_comparator cmp_b (
		.value({cmp_b_hi_r, cmp_b_lo_r}),
		.addr(cpu_addr),
		.qualify(qual),
		.cpu_read(cpu_read),
		.dir_en(cfg_r[CMP_B_DIRECTION_ENABLE_BIT]),
		.dir(cfg_r[RWB_BIT]),
		.hit(hb),
		.above(above_b),
		.below(below_b)
	);
	b_dir_guard_a: assert property (@(posedge core_clk) disable iff (rst)
		cfg_r[CMP_B_DIRECTION_ENABLE_BIT] && (cfg_r[RWB_BIT] != cpu_read) |-> !hb)
		else $error("comparator b hit on excluded direction");

	// trigger event per mode
	assign evmode = (trig_mode == MODE_EVENT_B) || (trig_mode == MODE_A_THEN_EVENT_B);
	assign data_b = qual && (cpu_data == cmp_b_lo_r);
	always_comb begin
		case (trig_mode)
			MODE_A_ONLY: trig_ev = ha;
			MODE_A_OR_B: trig_ev = ha || hb;
			MODE_A_THEN_B: trig_ev = a_seen_r && hb;
			MODE_A_AND_B: trig_ev = ha && data_b;
			MODE_A_NOT_B: trig_ev = ha && !data_b;
			MODE_INSIDE: trig_ev = qual && !below_a && !above_b;
			MODE_OUTSIDE: trig_ev = below_a || above_b;
			default: trig_ev = 1'b0;
		endcase
	end

	// event-only modes store B events, after A in the second one
	assign store_ev = hb && ((trig_mode == MODE_EVENT_B) || a_seen_r);
	always_comb begin
		if (evmode) begin
			capture = store_ev;
		end else begin
			capture = cpu_valid && cpu_opfetch &&
				((state_r == RUN_FILL) || (state_r == RUN_SEEK && !begin_trace));
		end
	end
	assign full_now = capture && (cnt_r == CNT_FULL - 4'h1);

	// run sequencing
	always_comb begin
		state_nxt = state_r;
		run_end = 1'b0;
		case (state_r)
			RUN_IDLE: begin
				state_nxt = RUN_IDLE;
			end
			RUN_SEEK: begin
				if (evmode) begin
					run_end = full_now;
				end else if (trig_ev && begin_trace) begin
					state_nxt = RUN_FILL;
				end else if (trig_ev) begin
					run_end = 1'b1;
				end
			end
			RUN_FILL: begin
				run_end = full_now;
			end
			default: begin
				state_nxt = RUN_IDLE;
			end
		endcase
		if (run_end) begin
			state_nxt = RUN_IDLE;
		end
		if (wr_ctrl && (!en_nxt || !reg_wdata[ARM_BIT])) begin
			state_nxt = RUN_IDLE;
		end else if (start_run) begin
			state_nxt = RUN_SEEK;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r <= RUN_IDLE;
			active_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			active_r <= (state_nxt != RUN_IDLE);
		end
	end

	// valid count, cleared at run start, saturates at full
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 4'h0;
		end else if (start_run) begin
			cnt_r <= 4'h0;
		end else if (capture && cnt_r != CNT_FULL) begin
			cnt_r <= cnt_r + 4'h1;
		end
	end

	// match flags, a set in the start cycle still lands
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			a_seen_r <= 1'b0;
			af_r <= 1'b0;
			bf_r <= 1'b0;
		end else begin
			a_seen_r <= (a_seen_r && !start_run) || ha;
			af_r <= (af_r && !start_run) || ha;
			bf_r <= (bf_r && !start_run) || hb;
		end
	end

	// most recent opcode fetch address for profiling
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			last_op_r <= FIFO_RESET;
		end else if (cpu_valid && cpu_opfetch) begin
			last_op_r <= cpu_addr;
		end
	end

	// fifo feed: captures while armed, profiling on unarmed reads
	assign link.shift_en = capture || (rd_lo && !armed);
	assign link.shift_in = capture ? (evmode ? {8'h00, cpu_data} : cpu_addr) : last_op_r;
	capture_fifo #(.DEPTH(FIFO_DEPTH), .WIDTH(16)) fifo (
		.core_clk(core_clk),
		.rst(rst),
		.link(link.store)
	);

	// break request, force reset pulse
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			brk_r <= 1'b0;
			brk_tag_r <= 1'b0;
			sys_reset_r <= 1'b0;
		end else begin
			brk_r <= run_end && cfg_r[BRK_BIT];
			brk_tag_r <= cfg_r[BRK_BIT] && cfg_r[TAG_BIT];
			sys_reset_r <= reg_wr && bdm_access && (reg_index == IDX_FORCE_RESET) &&
				reg_wdata[FORCE_RESET_BIT];
		end
	end

	// read data, taken before the fifo shifts
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_r <= READ_ZERO;
		end else if (reg_rd) begin
			if (reg_index == IDX_CMP_A_HI) begin
				rdata_r <= cmp_a_hi_r;
			end else if (reg_index == IDX_CMP_A_LO) begin
				rdata_r <= cmp_a_lo_r;
			end else if (reg_index == IDX_CMP_B_HI) begin
				rdata_r <= cmp_b_hi_r;
			end else if (reg_index == IDX_CMP_B_LO) begin
				rdata_r <= cmp_b_lo_r;
			end else if (reg_index == IDX_FIFO_HI) begin
				rdata_r <= evmode ? READ_ZERO : link.head[15:8];
			end else if (reg_index == IDX_FIFO_LO) begin
				rdata_r <= link.head[7:0];
			end else if (reg_index == IDX_CONTROL) begin
				rdata_r <= {module_enable_bit_r, armed, cfg_r};
			end else begin
				rdata_r <= READ_ZERO;
			end
		end
	end

	assign reg_rdata = rdata_r;
	assign break_request = brk_r;
	assign break_is_tag = brk_tag_r;
	assign system_reset_req = sys_reset_r;
	assign capture_active = active_r;
	assign match_a_flag = af_r;
	assign match_b_flag = bf_r;
	assign fifo_valid_count = cnt_r;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence user_reset_write;
		reg_wr && !bdm_access && (reg_index == IDX_FORCE_RESET);
	endsequence
	sequence arm_write;
		wr_ctrl && reg_wdata[ARM_BIT] && reg_wdata[EN_BIT] && !secure;
	endsequence

	force_read_zero_a: assert property (reg_rd && reg_index == IDX_FORCE_RESET |=>
		reg_rdata == READ_ZERO)
		else $error("force reset register read not zero");
	user_write_ignored_a: assert property (user_reset_write |=> !system_reset_req)
		else $error("user write reached force reset");
	force_reset_a: assert property (reg_wr && bdm_access &&
		reg_index == IDX_FORCE_RESET && reg_wdata[0] |=> system_reset_req ##1 !system_reset_req)
		else $error("background force reset not a one cycle pulse");
	cmp_frozen_a: assert property (armed && reg_wr && reg_index == IDX_CMP_A_HI |=>
		cmp_a_hi_r == $past(cmp_a_hi_r))
		else $error("comparator byte changed while armed");
	upper_event_zero_a: assert property (reg_rd && reg_index == IDX_FIFO_HI && evmode |=>
		reg_rdata == READ_ZERO)
		else $error("fifo upper byte nonzero in event mode");
	upper_no_shift_a: assert property (reg_rd && reg_index == IDX_FIFO_HI && !capture |->
		!link.shift_en)
		else $error("fifo upper read advanced fifo");
	armed_no_adv_a: assert property (armed && rd_lo && !capture |-> !link.shift_en)
		else $error("armed lower read advanced fifo");
	profile_store_a: assert property (!armed && rd_lo |->
		link.shift_en && link.shift_in == last_op_r)
		else $error("profiling read did not store opcode address");
	secure_enable_a: assert property (secure && !module_enable_bit_r |=>
		!module_enable_bit_r)
		else $error("enable set while secure");
	arm_flag_a: assert property (arm_write |=> capture_active ##0 armed)
		else $error("arm write did not set arm flag");
	break_timing_a: assert property (run_end && cfg_r[BRK_BIT] |=>
		break_request && !capture_active)
		else $error("break missing at run end");
	fill_end_a: assert property (state_r == RUN_FILL && full_now && !wr_ctrl |=>
		state_r == RUN_IDLE && fifo_valid_count == CNT_FULL)
		else $error("begin trace did not end when full");
endmodule : onchip_debug_trace_module
`default_nettype wire

//--- debug_trace_pkg.sv
`default_nettype none
package debug_trace_pkg;
	// register index on the byte access port
	localparam logic [3:0] IDX_FORCE_RESET = 4'h0;
	localparam logic [3:0] IDX_CMP_A_HI = 4'h1;
	localparam logic [3:0] IDX_CMP_A_LO = 4'h2;
	localparam logic [3:0] IDX_CMP_B_HI = 4'h3;
	localparam logic [3:0] IDX_CMP_B_LO = 4'h4;
	localparam logic [3:0] IDX_FIFO_HI = 4'h5;
	localparam logic [3:0] IDX_FIFO_LO = 4'h6;
	localparam logic [3:0] IDX_CONTROL = 4'h7;
	// trace_control and force reset bit positions
	localparam int EN_BIT = 7;
	localparam int ARM_BIT = 6;
	localparam int TAG_BIT = 5;
	localparam int BRK_BIT = 4;
	localparam int RWA_BIT = 3;
	localparam int CMP_A_DIRECTION_ENABLE_BIT = 2;
	localparam int RWB_BIT = 1;
	localparam int CMP_B_DIRECTION_ENABLE_BIT = 0;
	localparam int FORCE_RESET_BIT = 0;
	// reset values
	localparam logic [7:0] CMP_RESET = 8'h00;
	localparam logic [5:0] CFG_RESET = 6'h00;
	localparam logic [15:0] FIFO_RESET = 16'h0000;
	localparam logic [7:0] READ_ZERO = 8'h00;
	// fifo depth and full count
	localparam int FIFO_DEPTH = 8;
	localparam logic [3:0] CNT_FULL = 4'h8;
	// trigger mode codes
	localparam logic [3:0] MODE_A_ONLY = 4'h0;
	localparam logic [3:0] MODE_A_OR_B = 4'h1;
	localparam logic [3:0] MODE_A_THEN_B = 4'h2;
	localparam logic [3:0] MODE_EVENT_B = 4'h3;
	localparam logic [3:0] MODE_A_THEN_EVENT_B = 4'h4;
	localparam logic [3:0] MODE_A_AND_B = 4'h5;
	localparam logic [3:0] MODE_A_NOT_B = 4'h6;
	localparam logic [3:0] MODE_INSIDE = 4'h7;
	localparam logic [3:0] MODE_OUTSIDE = 4'h8;
	typedef enum logic [1:0] {RUN_IDLE, RUN_SEEK, RUN_FILL} run_state_type;
endpackage : debug_trace_pkg
`default_nettype wire

//--- fifo_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fifo_link_if #(parameter int WIDTH = 16);
	logic shift_en;
	logic [WIDTH-1:0] shift_in;
	logic [WIDTH-1:0] head;
	modport ctrl (output shift_en, output shift_in, input head);
	modport store (input shift_en, input shift_in, output head);
endinterface : fifo_link_if
`default_nettype wire

//--- addr_comparator.sv
`timescale 1ns/1ps
`default_nettype none
module addr_comparator (
	input wire logic [15:0] value,
	input wire logic [15:0] addr,
	input wire logic qualify,
	input wire logic cpu_read,
	input wire logic dir_en,
	input wire logic dir,
	output logic hit,
	output logic above,
	output logic below
);
	logic dir_ok;
	// direction qualifier: dir 1 reads only, 0 writes only
	assign dir_ok = !dir_en || (dir == cpu_read);
	assign hit = qualify && dir_ok && (addr == value);
	assign above = qualify && dir_ok && (addr > value);
	assign below = qualify && dir_ok && (addr < value);
endmodule : addr_comparator
`default_nettype wire

//--- capture_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module capture_fifo
	import debug_trace_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH,
	parameter int WIDTH = 16
) (
	input wire logic core_clk,
	input wire logic rst,
	fifo_link_if.store link
);
	logic [WIDTH-1:0] word_r [DEPTH];
	// shift toward the head, new word enters at the last location
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				word_r[i] <= WIDTH'(FIFO_RESET);
			end
		end else if (link.shift_en) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				word_r[i] <= word_r[i+1];
			end
			word_r[DEPTH-1] <= link.shift_in;
		end
	end
	assign link.head = word_r[0];
	sequence eight_shifts;
		link.shift_en [*8];
	endsequence
	// a word pushed eight shifts ago reaches the head
	depth_eight_a: assert property (@(posedge core_clk) disable iff (rst)
		eight_shifts |=> link.head == $past(link.shift_in, 8))
		else $error("fifo head is not the word pushed eight shifts ago");
endmodule : capture_fifo
`default_nettype wire

//--- debug_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module debug_host_model
	import debug_trace_pkg::*;
(
	input wire logic core_clk,
	input wire logic [7:0] reg_rdata,
	output logic [3:0] reg_index,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata,
	output logic bdm_access
);
	// idle port at time zero
	initial begin
		reg_index = 4'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
		bdm_access = 1'b0;
	end
	// one write strobe; bdm marks a serial background command
	task automatic wr(input logic [3:0] idx, input logic [7:0] data, input logic bdm);
		@(negedge core_clk);
		reg_index = idx;
		reg_wdata = data;
		bdm_access = bdm;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		bdm_access = 1'b0;
		reg_wdata = ~data; // released data no longer shows the last value
	endtask : wr
	// one read strobe; data taken half a cycle after the read edge
	task automatic rd(input logic [3:0] idx, output logic [7:0] data);
		@(negedge core_clk);
		reg_index = idx;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		data = reg_rdata;
	endtask : rd
	// captured word: upper byte first, since the lower read shifts
	task automatic fetch_word(output logic [7:0] hi, output logic [7:0] lo);
		rd(IDX_FIFO_HI, hi);
		rd(IDX_FIFO_LO, lo);
	endtask : fetch_word
	// host resets the target through the background channel
	task automatic force_reset();
		wr(IDX_FORCE_RESET, 8'h01, 1'b1);
	endtask : force_reset
endmodule : debug_host_model
`default_nettype wire

//--- onchip_debug_trace_module_test.sv
`timescale 1ns/1ps
`default_nettype none
module onchip_debug_trace_module_test;
	import debug_trace_pkg::*;
	logic core_clk, rst, reg_wr, reg_rd, bdm_access, break_request, break_is_tag;
	logic system_reset_req, capture_active, match_a_flag, match_b_flag;
	logic cpu_valid, cpu_read, cpu_opfetch, begin_trace, secure, cpu_opexec, trigger_qualify_select;
	logic [3:0] reg_index, trig_mode, fifo_valid_count;
	logic [7:0] reg_wdata, reg_rdata, cpu_data, hi, lo, v1;
	logic [15:0] cpu_addr;
	logic seen;
	int err_count, n_compared, cycles;
	onchip_debug_trace_module u_onchip_debug_trace_module (.core_clk(core_clk), .rst(rst),
		.reg_index(reg_index), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.bdm_access(bdm_access), .reg_rdata(reg_rdata), .cpu_addr(cpu_addr),
		.cpu_data(cpu_data), .cpu_valid(cpu_valid), .cpu_read(cpu_read),
		.cpu_opfetch(cpu_opfetch), .cpu_opexec(cpu_opexec), .trig_mode(trig_mode),
		.begin_trace(begin_trace), .trigger_qualify_select(trigger_qualify_select),
		.secure(secure),
		.break_request(break_request), .break_is_tag(break_is_tag),
		.system_reset_req(system_reset_req), .capture_active(capture_active),
		.match_a_flag(match_a_flag), .match_b_flag(match_b_flag),
		.fifo_valid_count(fifo_valid_count));
	debug_host_model u_debug_host_model (.core_clk(core_clk), .reg_rdata(reg_rdata),
		.reg_index(reg_index), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.bdm_access(bdm_access));
	// 125 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// hang guard
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_count = err_count + 1;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("mismatches %0d compared %0d", err_count, n_compared);
		if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : check
	task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp, input string msg);
		logic [7:0] d;
		u_debug_host_model.rd(idx, d);
		check({8'h00, d}, {8'h00, exp}, msg);
	endtask : rd_chk
	task automatic wr(input logic [3:0] idx, input logic [7:0] data);
		u_debug_host_model.wr(idx, data, 1'b0);
	endtask : wr
	// one cpu bus cycle
	task automatic cpu_cyc(input logic [15:0] a, input logic [7:0] d, input logic r,
		input logic f);
		@(negedge core_clk);
		cpu_addr = a;
		cpu_data = d;
		cpu_read = r;
		cpu_opfetch = f;
		cpu_valid = 1'b1;
		@(negedge core_clk);
		cpu_valid = 1'b0;
		cpu_opfetch = 1'b0;
		cpu_addr = ~a; // released address does not linger
	endtask : cpu_cyc
	// looks for a break pulse within a few cycles
	task automatic wait_brk(input logic exp, input string msg);
		seen = 1'b0;
		repeat (6) begin
			if (break_request === 1'b1) seen = 1'b1;
			@(negedge core_clk);
		end
		check({15'h0, seen}, {15'h0, exp}, msg);
	endtask : wait_brk
	task automatic set_cmp(input logic [15:0] a, input logic [15:0] b);
		wr(IDX_CMP_A_HI, a[15:8]);
		wr(IDX_CMP_A_LO, a[7:0]);
		wr(IDX_CMP_B_HI, b[15:8]);
		wr(IDX_CMP_B_LO, b[7:0]);
	endtask : set_cmp
	// one end trace run: a miss cycle, then the cycle that triggers
	task automatic try_mode(input logic [3:0] md, input logic [15:0] a0, input logic [7:0] d0,
		input logic [15:0] a1, input logic [7:0] d1);
		trig_mode = md;
		wr(IDX_CONTROL, 8'hd0);
		cpu_cyc(a0, d0, 1'b1, 1'b0);
		wait_brk(1'b0, "mode miss");
		cpu_cyc(a1, d1, 1'b1, 1'b0);
		wait_brk(1'b1, "mode hit");
	endtask : try_mode
	initial begin
		err_count = 0;
		n_compared = 0;
		cycles = 0;
		{cpu_valid, cpu_read, cpu_opfetch, begin_trace, secure} = 5'h00;
		{cpu_opexec, trigger_qualify_select} = 2'b00;
		cpu_addr = 16'h0000;
		cpu_data = 8'h00;
		trig_mode = MODE_A_ONLY;
		rst = 1'b1;
		repeat (2) @(negedge core_clk);
		rst = 1'b0;
		// reset values and unmapped indices read zero
		for (int i = 0; i < 16; i++) if (i != 6) rd_chk(i[3:0], 8'h00, "reset read");
		// user write to force reset is ignored, background write resets
		u_debug_host_model.wr(IDX_FORCE_RESET, 8'h01, 1'b0);
		check({15'h0, system_reset_req}, 16'h0000, "user force reset");
		u_debug_host_model.force_reset();
		check({15'h0, system_reset_req}, 16'h0001, "reset pulse");
		@(negedge core_clk);
		check({15'h0, system_reset_req}, 16'h0000, "reset pulse end");
		rd_chk(IDX_FORCE_RESET, 8'h00, "force reset read");
		// register read-back
		set_cmp(16'ha55a, 16'h3cc3);
		rd_chk(IDX_CMP_A_HI, 8'ha5, "cmp a hi");
		rd_chk(IDX_CMP_A_LO, 8'h5a, "cmp a lo");
		rd_chk(IDX_CMP_B_HI, 8'h3c, "cmp b hi");
		rd_chk(IDX_CMP_B_LO, 8'hc3, "cmp b lo");
		wr(IDX_CONTROL, 8'h3f);
		rd_chk(IDX_CONTROL, 8'h3f, "control rw");
		// enable refused while secure
		secure = 1'b1;
		wr(IDX_CONTROL, 8'h80);
		rd_chk(IDX_CONTROL, 8'h00, "secure enable");
		secure = 1'b0;
		wr(IDX_CONTROL, 8'h80);
		rd_chk(IDX_CONTROL, 8'h80, "enable");
		// profiling: ninth lower read returns what the first stored
		for (int k = 0; k < 10; k++) begin
			cpu_cyc({8'h40 + k[7:0], 8'h30 + k[7:0]}, 8'h00, 1'b1, 1'b1);
			u_debug_host_model.fetch_word(hi, lo);
			if (k >= 8) check({hi, lo}, {8'h38 + k[7:0], 8'h28 + k[7:0]}, "profile");
		end
		// end trace on comparator A, reads only, tag break
		set_cmp(16'h4321, 16'h9999);
		wr(IDX_CONTROL, 8'hfc);
		check({15'h0, capture_active}, 16'h0001, "armed");
		wr(IDX_CMP_A_HI, 8'hff);
		check({15'h0, break_is_tag}, 16'h0001, "tag type");
		rd_chk(IDX_CMP_A_HI, 8'h43, "armed cmp write");
		rd_chk(IDX_CONTROL, 8'hfc, "control while armed");
		u_debug_host_model.rd(IDX_FIFO_LO, v1);
		rd_chk(IDX_FIFO_LO, v1, "armed fifo hold");
		cpu_cyc(16'h4321, 8'h00, 1'b0, 1'b0);
		wait_brk(1'b0, "write ignored by a");
		cpu_cyc(16'h4320, 8'h00, 1'b1, 1'b0);
		wait_brk(1'b0, "address miss");
		cpu_cyc(16'h4321, 8'h00, 1'b1, 1'b0);
		wait_brk(1'b1, "a read break");
		check({15'h0, capture_active}, 16'h0000, "run end");
		check({15'h0, match_a_flag}, 16'h0001, "a flag");
		// comparator B, writes only, force break
		set_cmp(16'h0001, 16'h5678);
		trig_mode = MODE_A_OR_B;
		wr(IDX_CONTROL, 8'hd1);
		cpu_cyc(16'h5678, 8'h00, 1'b1, 1'b0);
		wait_brk(1'b0, "read ignored by b");
		check({15'h0, break_is_tag}, 16'h0000, "force type");
		cpu_cyc(16'h5678, 8'h00, 1'b0, 1'b0);
		wait_brk(1'b1, "b write break");
		check({15'h0, match_b_flag}, 16'h0001, "b flag");
		// stopping a run by clearing arm
		wr(IDX_CONTROL, 8'hc0);
		check({15'h0, capture_active}, 16'h0001, "rearmed");
		wr(IDX_CONTROL, 8'h80);
		check({15'h0, capture_active}, 16'h0000, "manual stop");
		// remaining trigger modes, each with a miss before the trigger
		set_cmp(16'h1000, 16'h2000);
		try_mode(MODE_A_THEN_B, 16'h1000, 8'h11, 16'h2000, 8'h11);
		try_mode(MODE_A_AND_B, 16'h1000, 8'h11, 16'h1000, 8'h00);
		try_mode(MODE_A_NOT_B, 16'h1000, 8'h00, 16'h1000, 8'h11);
		try_mode(MODE_INSIDE, 16'h0fff, 8'h00, 16'h1800, 8'h00);
		try_mode(MODE_OUTSIDE, 16'h1800, 8'h00, 16'h2001, 8'h00);
		// begin trace on an executed opcode, then eight fetches back to back
		set_cmp(16'h5000, 16'hffff);
		trig_mode = MODE_A_ONLY;
		begin_trace = 1'b1;
		trigger_qualify_select = 1'b1;
		wr(IDX_CONTROL, 8'hd0);
		cpu_cyc(16'h5000, 8'h00, 1'b1, 1'b1);
		check({15'h0, match_a_flag}, 16'h0000, "unexecuted match");
		cpu_opexec = 1'b1;
		cpu_cyc(16'h5000, 8'h00, 1'b1, 1'b1);
		cpu_opexec = 1'b0;
		wait_brk(1'b0, "no break at begin trigger");
		@(negedge core_clk);
		{cpu_valid, cpu_opfetch} = 2'b11;
		for (int i = 0; i < 8; i++) begin
			cpu_addr = {8'h60, i[7:0]};
			if (i == 7) check({15'h0, capture_active}, 16'h0001, "filling");
			@(negedge core_clk);
		end
		{cpu_valid, cpu_opfetch} = 2'b00;
		wait_brk(1'b1, "begin trace full break");
		check({12'h0, fifo_valid_count}, 16'h0008, "begin valid count");
		for (int i = 0; i < 8; i++) begin
			u_debug_host_model.fetch_word(hi, lo);
			check({hi, lo}, {8'h60, i[7:0]}, "begin trace word");
		end
		{begin_trace, trigger_qualify_select} = 2'b00;
		// event-only modes store bytes on B hits
		for (int m = 0; m < 2; m++) begin
			set_cmp(16'h2000, 16'h3000);
			trig_mode = (m == 0) ? MODE_EVENT_B : MODE_A_THEN_EVENT_B;
			wr(IDX_CONTROL, 8'hd0);
			if (m == 1) cpu_cyc(16'h2000, 8'h00, 1'b1, 1'b0);
			for (int i = 0; i < 7; i++) cpu_cyc(16'h3000, 8'h10 + i[7:0] + m[7:0] * 8, 1'b0, 1'b0);
			check({15'h0, capture_active}, 16'h0001, "still armed");
			cpu_cyc(16'h3000, 8'h17 + m[7:0] * 8, 1'b0, 1'b0);
			wait_brk(1'b1, "fifo full break");
			check({12'h0, fifo_valid_count}, 16'h0008, "valid count");
			wr(IDX_FIFO_LO, 8'haa);
			wr(IDX_FIFO_HI, 8'h55);
			for (int i = 0; i < 8; i++) begin
				rd_chk(IDX_FIFO_HI, 8'h00, "event upper");
				rd_chk(IDX_FIFO_HI, 8'h00, "event upper again");
				rd_chk(IDX_FIFO_LO, 8'h10 + i[7:0] + m[7:0] * 8, "event byte");
			end
		end
		end_of_test();
	end
endmodule : onchip_debug_trace_module_test
`default_nettype wire
